// *** psb_consts.vh ***
// Constants for the parallel slave buffer status block
`ifndef PSB_CONSTS_VH
`define PSB_CONSTS_VH

// Register addresses on the plain register port
`define PSB_ADDR_W 4
`define PSB_A_FLAGS 4'h0
`define PSB_A_CTRL 4'h1
`define PSB_A_IRQ_STAT 4'h2
`define PSB_A_IRQ_EN 4'h3
`define PSB_A_IRQ_CLR 4'h4
`define PSB_A_IN0 4'h8
`define PSB_A_OUT0 4'hC
// Buffer pages: address bits above the buffer index
`define PSB_A_PAGE_LO 2
`define PSB_A_IN_PAGE 2'h2
`define PSB_A_OUT_PAGE 2'h3

// Field positions in the flags register
`define PSB_F_IN_ALL 15
`define PSB_F_IN_OVF 14
`define PSB_F_IN_FULL_HI 11
`define PSB_F_IN_FULL_LO 8
`define PSB_F_OUT_ALL 7
`define PSB_F_OUT_UNF 6
`define PSB_F_OUT_EMPTY_HI 3
`define PSB_F_OUT_EMPTY_LO 0

// Control bit: slave mode enable
`define PSB_C_SLAVE 0

// Interrupt status layout
`define PSB_I_OVF 0
`define PSB_I_UNF 1
`define PSB_I_IN_ALL 2
`define PSB_I_OUT_ALL 3
`define PSB_IRQ_W 4

// Widths and reset values
`define PSB_NBUF 4
`define PSB_BYTE_W 8
`define PSB_DATA_W 16
`define PSB_ZERO16 16'h0000
`define PSB_ZERO8 8'h00
`define PSB_ZERO4 4'h0
`define PSB_ZERO2 2'h0
`define PSB_ONES4 4'hF

`endif

// *** psb_sync.v ***
// Two-flop synchroniser for one pin-level input
module psb_sync (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Asynchronous input and synchronised output
    input wire pin_in,
    output reg pin_sync
);
    // First stage, read only by the second stage
    reg meta;

    // Shift the pin through two flops to settle metastability
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            meta <= pin_in;
            pin_sync <= meta;
        end
    end
endmodule // psb_sync

// *** psb_edge.v ***
// Rising-edge pulse generator for a synchronised strobe
module psb_edge (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Synchronised level in, one-cycle pulse out
    input wire level,
    output wire pulse
);
    // Previous level sample
    reg level_d;

    // Remember last level
    always @(posedge core_clk)
    begin
        if (!rst_n)
            level_d <= 1'b0;
        else
            level_d <= level;
    end

    // Pulse on low-to-high transition only
    assign pulse = level & ~level_d;
endmodule // psb_edge

// *** psb_top.v ***
// Parallel slave port buffers with status flags, errors and interrupt
// Register map on the plain register port
//   0x0  flags word, read only apart from the two error bits
//   0x1  control; bit 0 puts the port into slave operation
//   0x2  interrupt status, read only, sticky per event
//   0x3  interrupt enable, same layout as the status
//   0x4  interrupt clear, write only, a one clears a bit
//   0x8..0xB  input buffers, a read frees the buffer
//   0xC..0xF  output buffers, a write fills the buffer
//   Other addresses read zero and ignore writes
//
// Error bits: writing zero clears, writing one keeps the bit; a
// hardware set in the same cycle as the clear wins, so no event is lost.
//
// Interrupt events: bit 0 overflow, bit 1 underflow, bit 2 inputs
// became all full, bit 3 outputs became all empty.
//
// Host timing: strobes, address and data pass two flops each, so an
// access is seen about three cycles after the strobe falls. The host
// must hold address and data steady from three cycles before the
// strobe until it rises, and keep the strobe low at least four cycles
// and high at least three between accesses.
// Limitation: the data pins are synchronised bit by bit, so a byte that
// changes while the strobe is low may be taken as a mix of old and new.
`include "psb_consts.vh"

module psb_top (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port, read data one cycle after the read strobe
    input wire [`PSB_ADDR_W-1:0] reg_addr,
    input wire [`PSB_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`PSB_DATA_W-1:0] reg_rdata,
    // Host side pins, asynchronous to core_clk
    input wire [1:0] host_addr,
    input wire host_wr_n,
    input wire host_rd_n,
    input wire [`PSB_BYTE_W-1:0] host_data_in,
    output reg [`PSB_BYTE_W-1:0] host_data_out,
    output reg host_data_oe,
    // Interrupt
    output reg irq
);
    // Synchronised strobe levels, high while the host strobe is low
    wire wr_sync;
    wire rd_sync;
    // One-cycle pulses at the start of each host access
    wire wr_pulse;
    wire rd_pulse;
    // Synchronised address and data, valid while the host holds them
    wire [1:0] haddr_sync;
    wire [`PSB_BYTE_W-1:0] hdata_sync;
    // Buffers
    reg [`PSB_BYTE_W-1:0] in_buf [0:`PSB_NBUF-1];
    reg [`PSB_BYTE_W-1:0] out_buf [0:`PSB_NBUF-1];
    // Per-buffer flags
    reg [`PSB_NBUF-1:0] input_byte_full_flags; // One per input buffer, high while unread
    reg [`PSB_NBUF-1:0] output_byte_empty_flags; // One per output buffer, high while empty
    // Sticky error flags
    reg input_overflow; // Host wrote a full input buffer
    reg output_underflow; // Host read an empty output buffer
    // Control and interrupt state
    reg slave_en; // Port works as a slave to the host
    reg [`PSB_IRQ_W-1:0] irq_stat; // Sticky event bits
    reg [`PSB_IRQ_W-1:0] irq_en; // Event enables
    // Summary flags, combinational from per-buffer flags
    wire input_all_full; // High when every input buffer is full
    wire output_all_empty; // High when every output buffer is empty
    // Status word as software sees it
    wire [`PSB_DATA_W-1:0] flags_word;
    // Interrupt events, one cycle pulses
    wire [`PSB_IRQ_W-1:0] irq_evt;
    // Host accesses qualified by slave mode
    wire host_wr_evt; // Host write seen
    wire host_rd_evt; // Host read seen
    // Internal side buffer access decode
    wire [1:0] sw_idx; // Buffer index from the address
    wire sw_in_rd; // Internal read of an input buffer
    wire sw_out_wr; // Internal write of an output buffer
    // Summary flags one cycle ago, for transition events
    reg input_all_full_d;
    reg output_all_empty_d;
    // Read mux output, registered into reg_rdata
    reg [`PSB_DATA_W-1:0] next_rdata;

    // Strobes are active low on the pins; invert before edge detection
    // Each strobe crosses on its own pair of flops; the edge detector
    // then turns the settled level into one pulse per access
    psb_sync u_sync_wr (.core_clk(core_clk), .rst_n(rst_n), .pin_in(~host_wr_n),
        .pin_sync(wr_sync));
    psb_sync u_sync_rd (.core_clk(core_clk), .rst_n(rst_n), .pin_in(~host_rd_n),
        .pin_sync(rd_sync));
    psb_edge u_edge_wr (.core_clk(core_clk), .rst_n(rst_n), .level(wr_sync),
        .pulse(wr_pulse));
    psb_edge u_edge_rd (.core_clk(core_clk), .rst_n(rst_n), .level(rd_sync),
        .pulse(rd_pulse));

    // Address and data bits each pass two flops; host must hold them stable
    // across the strobe, since a bit-wise synchroniser cannot keep a bus coherent
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_addr
            psb_sync u_s (.core_clk(core_clk), .rst_n(rst_n), .pin_in(host_addr[gi]),
                .pin_sync(haddr_sync[gi]));
        end
        for (gi = 0; gi < `PSB_BYTE_W; gi = gi + 1)
        begin : g_data
            psb_sync u_s (.core_clk(core_clk), .rst_n(rst_n), .pin_in(host_data_in[gi]),
                .pin_sync(hdata_sync[gi]));
        end
    endgenerate

    // Host accesses count only while the port is a slave
    // Outside slave operation the host cannot fill, drain or flag anything
    assign host_wr_evt = wr_pulse & slave_en;
    assign host_rd_evt = rd_pulse & slave_en;

    // Internal side buffer selection from the low address bits
    // The upper address bits pick the page: input buffers, output buffers
    // or the control registers, so one compare decodes four addresses
    assign sw_idx = reg_addr[`PSB_A_PAGE_LO-1:0];
    assign sw_in_rd = reg_rd && (reg_addr[`PSB_ADDR_W-1:`PSB_A_PAGE_LO] == `PSB_A_IN_PAGE);
    assign sw_out_wr = reg_wr && (reg_addr[`PSB_ADDR_W-1:`PSB_A_PAGE_LO] == `PSB_A_OUT_PAGE);

    // Summary flags recomputed every cycle
    // No storage of their own: they can never disagree with the
    // per-buffer flags, at the cost of a four-input AND in the read path
    assign input_all_full = &input_byte_full_flags;
    assign output_all_empty = &output_byte_empty_flags;

    // Flags word; unused bit positions are constant zero
    // Built from wires rather than stored, so the unused bits have no
    // storage that a write could ever reach
    assign flags_word = {input_all_full, input_overflow, `PSB_ZERO2,
        input_byte_full_flags, output_all_empty, output_underflow, `PSB_ZERO2,
        output_byte_empty_flags};

    // Per-buffer flag and data storage, one slice per buffer
    // All buffers reset empty, so the input full flags start low and the
    // output empty flags start high
    generate
        for (gi = 0; gi < `PSB_NBUF; gi = gi + 1)
        begin : g_buf
            always @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    in_buf[gi] <= `PSB_ZERO8;
                    out_buf[gi] <= `PSB_ZERO8;
                    input_byte_full_flags[gi] <= 1'b0;
                    output_byte_empty_flags[gi] <= 1'b1;
                end
                else
                begin
                    // Host write fills an empty input buffer; a full one keeps old data
                    // The byte already there is not lost; overflow reports the attempt
                    if (host_wr_evt && haddr_sync == gi && !input_byte_full_flags[gi])
                    begin
                        in_buf[gi] <= hdata_sync;
                        input_byte_full_flags[gi] <= 1'b1;
                    end
                    else if (sw_in_rd && sw_idx == gi)
                        input_byte_full_flags[gi] <= 1'b0;
                    // Internal write wins over a same-cycle host read
                    // so the new byte stays marked full for the next host read
                    if (sw_out_wr && sw_idx == gi)
                    begin
                        out_buf[gi] <= reg_wdata[`PSB_BYTE_W-1:0];
                        output_byte_empty_flags[gi] <= 1'b0;
                    end
                    else if (host_rd_evt && haddr_sync == gi)
                        output_byte_empty_flags[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Sticky errors: hardware set wins over a same-cycle software clear
    // Writing zero clears an error bit and writing one keeps it, so a
    // read-modify-write of the flags word in slave mode never clears an error by accident
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            input_overflow <= 1'b0;
            output_underflow <= 1'b0;
        end
        else
        begin
            if (host_wr_evt && input_byte_full_flags[haddr_sync])
                input_overflow <= 1'b1;
            else if (reg_wr && reg_addr == `PSB_A_FLAGS && !reg_wdata[`PSB_F_IN_OVF])
                input_overflow <= 1'b0;
            if (host_rd_evt && output_byte_empty_flags[haddr_sync])
                output_underflow <= 1'b1;
            else if (reg_wr && reg_addr == `PSB_A_FLAGS && !reg_wdata[`PSB_F_OUT_UNF])
                output_underflow <= 1'b0;
        end
    end

    // Events: each overflow or underflow attempt and summary transitions to all-full / all-empty
    // The summary events fire on the transition only, so a buffer set that
    // stays full raises one interrupt, not one per cycle
    assign irq_evt[`PSB_I_OVF] = host_wr_evt & input_byte_full_flags[haddr_sync];
    assign irq_evt[`PSB_I_UNF] = host_rd_evt & output_byte_empty_flags[haddr_sync];
    assign irq_evt[`PSB_I_IN_ALL] = input_all_full & ~input_all_full_d;
    assign irq_evt[`PSB_I_OUT_ALL] = output_all_empty & ~output_all_empty_d;

    // Control, interrupt status and enable registers
    // The delayed summaries reset to the reset values of the summaries
    // themselves, so no false transition event follows reset
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            slave_en <= 1'b0;
            irq_en <= `PSB_ZERO4;
            irq_stat <= `PSB_ZERO4;
            input_all_full_d <= 1'b0;
            output_all_empty_d <= 1'b1;
            irq <= 1'b0;
        end
        else
        begin
            input_all_full_d <= input_all_full;
            output_all_empty_d <= output_all_empty;
            if (reg_wr && reg_addr == `PSB_A_CTRL)
                slave_en <= reg_wdata[`PSB_C_SLAVE];
            if (reg_wr && reg_addr == `PSB_A_IRQ_EN)
                irq_en <= reg_wdata[`PSB_IRQ_W-1:0];
            // Clear applies first, then new events are OR-ed so sets win
            if (reg_wr && reg_addr == `PSB_A_IRQ_CLR)
                irq_stat <= (irq_stat & ~reg_wdata[`PSB_IRQ_W-1:0]) | irq_evt;
            else
                irq_stat <= irq_stat | irq_evt;
            // Registered level interrupt; one cycle behind the status bit
            irq <= |(irq_stat & irq_en);
        end
    end

    // Read mux, registered so data stands the cycle after the strobe
    // Buffer contents show only during an actual read strobe, so a
    // stray address on the bus never exposes input data
    always @*
    begin
        next_rdata = `PSB_ZERO16;
        case (reg_addr)
            `PSB_A_FLAGS: next_rdata = slave_en ? flags_word : `PSB_ZERO16;
            `PSB_A_CTRL: next_rdata = {15'h0000, slave_en};
            `PSB_A_IRQ_STAT: next_rdata = {12'h000, irq_stat};
            `PSB_A_IRQ_EN: next_rdata = {12'h000, irq_en};
            default:
            begin
                if (sw_in_rd)
                    next_rdata = {8'h00, in_buf[sw_idx]};
                else
                    next_rdata = `PSB_ZERO16;
            end
        endcase
    end

    // Read data register; holds only in the cycle after the read strobe
    // Zero outside the answer cycle keeps a shared read bus quiet
    always @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= `PSB_ZERO16;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= `PSB_ZERO16;
    end

    // Host read data path; drives the bus while the host strobe is active in slave mode
    // The byte is latched at the detected strobe edge and then holds, so
    // the host sees a steady value for the rest of its strobe
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            host_data_out <= `PSB_ZERO8;
            host_data_oe <= 1'b0;
        end
        else
        begin
            host_data_oe <= rd_sync & slave_en;
            if (host_rd_evt)
                host_data_out <= out_buf[haddr_sync];
        end
    end
endmodule // psb_top

// *** psb_host.sv ***
// Host-side model that drives the parallel slave pins
module psb_host (
    // Clock
    input wire core_clk,
    // Host pins
    output reg [1:0] host_addr,
    output reg host_wr_n,
    output reg host_rd_n,
    output reg [7:0] host_data_in,
    input wire [7:0] host_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels: both strobes high
    initial
    begin
        host_addr = 2'h0;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_data_in = 8'h00;
    end
    // One byte transfer; setup 3, low 5, high 4 cycles cover the synchroniser lag
    task xfer(input wr, input [1:0] a, input [7:0] d, output [7:0] q);
    begin
        @(posedge core_clk);
        host_addr <= a;
        if (wr)
            host_data_in <= d;
        repeat (3) @(posedge core_clk);
        host_wr_n <= !wr;
        host_rd_n <= wr;
        repeat (5) @(posedge core_clk);
        q = host_data_out;
        host_wr_n <= 1'b1;
        host_rd_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        // Released lines carry no stale byte
        host_data_in <= ~host_data_in;
    end
    endtask
endmodule // psb_host

// *** psb_top_chk.sv ***
// Port checker for the parallel slave buffer status block
`include "psb_consts.vh"
module psb_chk (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    // Host pins
    input wire host_rd_n,
    input wire host_data_oe,
    // Interrupt
    input wire irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    reg slave_q; // Shadow of the slave enable bit
    reg rd_q; // Read strobe one cycle ago
    reg [3:0] ra_q; // Read address one cycle ago
    // Shadow state, so the flags word can be judged in its answer cycle
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            slave_q <= 1'b0;
            rd_q <= 1'b0;
            ra_q <= 4'h0;
        end
        else
        begin
            rd_q <= reg_rd;
            ra_q <= reg_addr;
            if (reg_wr && reg_addr == `PSB_A_CTRL)
                slave_q <= reg_wdata[0];
        end
    end
    a_rdata_idle: assert property (!rd_q |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside answer cycle");
    a_unused_zero: assert property (rd_q && ra_q == `PSB_A_FLAGS |->
        reg_rdata[13:12] == 2'h0 && reg_rdata[5:4] == 2'h0)
        else $error("unused flag bits not zero");
    a_all_full: assert property (rd_q && ra_q == `PSB_A_FLAGS |->
        reg_rdata[15] == &reg_rdata[11:8]) else $error("input summary wrong");
    a_all_empty: assert property (rd_q && ra_q == `PSB_A_FLAGS |->
        reg_rdata[7] == &reg_rdata[3:0]) else $error("output summary wrong");
    a_slave_off: assert property (rd_q && ra_q == `PSB_A_FLAGS && !slave_q |->
        reg_rdata == 16'h0000) else $error("flags visible outside slave mode");
    a_unmapped_zero: assert property (rd_q && ra_q > 4'h4 && ra_q < 4'h8 |->
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_oe_release: assert property (host_rd_n [*5] |=> !host_data_oe)
        else $error("output enable held without read strobe");
    a_oe_drive: assert property ((slave_q && !host_rd_n) [*4] |-> host_data_oe)
        else $error("output enable low during host read");
    a_irq_masked: assert property (reg_wr && reg_addr == `PSB_A_IRQ_EN &&
        reg_wdata[3:0] == 4'h0 |=> ##1 !irq) else $error("irq high while all masked");
endmodule // psb_chk
bind psb_top psb_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_rd_n(host_rd_n), .host_data_oe(host_data_oe), .irq(irq));

// *** psb_top_test.sv ***
// Self-checking bench for the parallel slave buffer status block
`include "psb_consts.vh"
module psb_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    reg core_clk, rst_n, reg_wr, reg_rd;
    reg [3:0] reg_addr;
    reg [15:0] reg_wdata;
    wire [15:0] reg_rdata;
    wire [1:0] host_addr;
    wire host_wr_n, host_rd_n, host_data_oe, irq;
    wire [7:0] host_data_in, host_data_out;
    integer error_cnt = 0, n_checks = 0, cyc = 0, i;
    reg [7:0] hb; // Byte seen by the host
    reg [3:0] m; // Expected per-buffer flag mask
    psb_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_addr(host_addr), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .irq(irq));
    psb_host u_host (.core_clk(core_clk), .host_addr(host_addr), .host_wr_n(host_wr_n),
        .host_rd_n(host_rd_n), .host_data_in(host_data_in), .host_data_out(host_data_out));
    // Compare and count
    task chk(input [15:0] seen, input [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    // Register write, one strobe cycle
    task wr(input [3:0] a, input [15:0] d);
    begin
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    end
    endtask
    // Register read; data stands only in the following cycle
    task rd(input [3:0] a, input [15:0] e);
    begin
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    end
    endtask
    task conclude;
    begin
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`PSB_A_FLAGS, 16'h0000);
        u_host.xfer(1'b1, 2'h0, 8'h55, hb);
        wr(`PSB_A_CTRL, 16'h0001);
        rd(`PSB_A_FLAGS, 16'h008F);
        wr(`PSB_A_IRQ_EN, 16'h000F);
        // Fill the input buffers one by one
        for (i = 0; i < 4; i = i + 1)
        begin
            u_host.xfer(1'b1, i[1:0], 8'h10 + i[7:0], hb);
            m = 4'hF >> (3 - i);
            rd(`PSB_A_FLAGS, {m == 4'hF, 3'h0, m, 8'h8F});
        end
        chk({15'h0000, irq}, 16'h0001);
        u_host.xfer(1'b1, 2'h2, 8'hEE, hb);
        rd(`PSB_A_FLAGS, 16'hCF8F);
        for (i = 0; i < 4; i = i + 1)
            rd(`PSB_A_IN0 + i[3:0], 16'h0010 + i[15:0]);
        rd(`PSB_A_FLAGS, 16'h408F);
        wr(`PSB_A_FLAGS, 16'hFFFF);
        rd(`PSB_A_FLAGS, 16'h408F);
        wr(`PSB_A_FLAGS, 16'h0000);
        rd(`PSB_A_FLAGS, 16'h008F);
        rd(`PSB_A_IRQ_STAT, 16'h0005);
        wr(`PSB_A_IRQ_CLR, 16'h000F);
        rd(`PSB_A_IRQ_STAT, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // Internal writes clear the output empty flags
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`PSB_A_OUT0 + i[3:0], 16'h00A0 + i[15:0]);
            rd(`PSB_A_FLAGS, {12'h000, 4'hE << i});
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            u_host.xfer(1'b0, i[1:0], 8'h00, hb);
            chk({8'h00, hb}, 16'h00A0 + i[15:0]);
        end
        rd(`PSB_A_FLAGS, 16'h008F);
        u_host.xfer(1'b0, 2'h1, 8'h00, hb);
        rd(`PSB_A_FLAGS, 16'h00CF);
        rd(`PSB_A_IRQ_STAT, 16'h000A);
        wr(`PSB_A_IRQ_EN, 16'h0000);
        rd(`PSB_A_IRQ_STAT, 16'h000A);
        chk({15'h0000, irq}, 16'h0000);
        wr(`PSB_A_IRQ_EN, 16'h0002);
        rd(`PSB_A_IRQ_STAT, 16'h000A);
        chk({15'h0000, irq}, 16'h0001);
        wr(`PSB_A_FLAGS, 16'h0000);
        rd(`PSB_A_FLAGS, 16'h008F);
        wr(4'h7, 16'hFFFF);
        rd(4'h7, 16'h0000);
        wr(`PSB_A_CTRL, 16'h0000);
        rd(`PSB_A_FLAGS, 16'h0000);
        conclude;
    end
endmodule // psb_top_test
